// >>> shared/pcec_pkg.sv
package pcec_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] CMD_OFS = 12'h004;
  localparam logic [11:0] ERRSTAT_OFS = 12'h008;
  localparam logic [11:0] ERRCNT_OFS = 12'h00c;
  // ****************************************
  // command field positions
  // ****************************************
  localparam int SPC_POS = 3;
  localparam int MWI_POS = 4;
  localparam int PAL_POS = 5;
  localparam int PER_POS = 6;
  localparam int WAIT_POS = 7;
  localparam int SERR_POS = 8;
  localparam int FBB_POS = 9;
  // status register bit positions
  localparam int DPE_POS = 0;
  localparam int NF_POS = 1;
  localparam int FT_POS = 2;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic PER_RST = 1'h0;
  localparam logic SERR_RST = 1'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;
endpackage

// >>> shared/pcec_err_if.sv
`timescale 1ns/100ps
interface pcec_err_if;
  logic par_err;
  logic per_en;
  logic serr_en;
  logic par_resp;
  logic dpe_set;
  modport regs (output per_en, output serr_en, input par_resp,
    input dpe_set);
  modport chk (input par_err, input per_en, output par_resp,
    output dpe_set);
endinterface

// >>> logic/pcec_parity.sv
`timescale 1ns/100ps
module pcec_parity (
  pcec_err_if.chk err
);
  // ****************************************
  // parity error steering
  // ****************************************
  always_comb begin
    // the status flag is set regardless of the enable
    err.dpe_set = err.par_err;
    err.par_resp = err.par_err & err.per_en;
  end
endmodule

// >>> logic/pcec_top.sv
`timescale 1ns/100ps
module pcec_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic parity_err_det,
  input wire logic nonfatal_det,
  input wire logic fatal_det,
  output logic parity_resp,
  output logic nonfatal_msg,
  output logic fatal_msg,
  output logic per_en_o,
  output logic serr_en_o
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic per;
    logic serr;
    logic dpe;
    logic nf;
    logic ft;
    logic [15:0] cnt;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic resp;
    logic nf_out;
    logic ft_out;
  } pcec_state_t;

  pcec_state_t st_ff;
  pcec_state_t nxt_st;
  pcec_err_if eif ();

  assign eif.par_err = parity_err_det;
  assign eif.per_en = st_ff.per;
  assign eif.serr_en = st_ff.serr;

  pcec_parity u_par (
    .err(eif)
  );

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  logic access;
  logic wr;
  logic [31:0] w1c;
  assign access = psel & penable & ~st_ff.ready;
  assign wr = access & pwrite;
  assign w1c = (wr & hit(paddr, pcec_pkg::ERRSTAT_OFS) & pstrb[0]) ?
    pwdata : 32'h00000000;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ready = access;
    nxt_st.slverr = 1'b0;
    nxt_st.rdata = 32'h00000000;
    // only the two enables hold written data, the rest stay zero
    if (wr && hit(paddr, pcec_pkg::CMD_OFS)) begin
      if (pstrb[0]) begin
        nxt_st.per = pwdata[pcec_pkg::PER_POS];
      end
      if (pstrb[1]) begin
        nxt_st.serr = pwdata[pcec_pkg::SERR_POS];
      end
    end
    // a status flag set wins over its clear in the same cycle, but a counter clear wins over the increment
    if (w1c[pcec_pkg::DPE_POS]) begin
      nxt_st.dpe = 1'b0;
    end
    if (w1c[pcec_pkg::NF_POS]) begin
      nxt_st.nf = 1'b0;
    end
    if (w1c[pcec_pkg::FT_POS]) begin
      nxt_st.ft = 1'b0;
    end
    if (eif.dpe_set) begin
      nxt_st.dpe = 1'b1;
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
    if (nonfatal_det) begin
      nxt_st.nf = 1'b1;
    end
    if (fatal_det) begin
      nxt_st.ft = 1'b1;
    end
    if (wr && hit(paddr, pcec_pkg::ERRCNT_OFS)) begin
      nxt_st.cnt = pcec_pkg::CNT_RST;
    end
    nxt_st.resp = eif.par_resp;
    // suppressed errors are dropped, not held for later
    nxt_st.nf_out = nonfatal_det & st_ff.serr;
    nxt_st.ft_out = fatal_det & st_ff.serr;
    if (access && !pwrite) begin
      unique case (paddr)
        pcec_pkg::CMD_OFS: begin
          // hardwired bits never driven here
          nxt_st.rdata[pcec_pkg::PER_POS] = st_ff.per;
          nxt_st.rdata[pcec_pkg::SERR_POS] = st_ff.serr;
        end
        pcec_pkg::ERRSTAT_OFS: begin
          nxt_st.rdata[pcec_pkg::DPE_POS] = st_ff.dpe;
          nxt_st.rdata[pcec_pkg::NF_POS] = st_ff.nf;
          nxt_st.rdata[pcec_pkg::FT_POS] = st_ff.ft;
        end
        pcec_pkg::ERRCNT_OFS: begin
          nxt_st.rdata[15:0] = st_ff.cnt;
        end
        default: begin
          nxt_st.slverr = 1'b1;
        end
      endcase
    end
    if (wr && !hit(paddr, pcec_pkg::CMD_OFS) &&
        !hit(paddr, pcec_pkg::ERRSTAT_OFS) &&
        !hit(paddr, pcec_pkg::ERRCNT_OFS)) begin
      nxt_st.slverr = 1'b1;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.per <= pcec_pkg::PER_RST;
      st_ff.serr <= pcec_pkg::SERR_RST;
      st_ff.cnt <= pcec_pkg::CNT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.slverr;
  assign parity_resp = st_ff.resp;
  assign nonfatal_msg = st_ff.nf_out;
  assign fatal_msg = st_ff.ft_out;
  assign per_en_o = st_ff.per;
  assign serr_en_o = st_ff.serr;
endmodule

// >>> test/pcec_monitor.sv
`timescale 1ns/100ps
module pcec_monitor (
  input wire logic clk, rst, psel, penable, pwrite, pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  input wire logic parity_err_det, fatal_det, parity_resp, fatal_msg,
  input wire logic per_en_o, serr_en_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire cmd = psel && penable && pready && paddr == pcec_pkg::CMD_OFS;
  property p_zero; cmd && !pwrite |-> !(prdata & 32'h2b8); endproperty
  a_zero: assert property (p_zero)
    else $error("fixed bit set");
  property p_resp; parity_err_det && per_en_o |=> parity_resp; endproperty
  a_resp: assert property (p_resp)
    else $error("no response");
  property p_quiet; parity_err_det && !per_en_o |=> !parity_resp; endproperty
  a_quiet: assert property (p_quiet)
    else $error("response while off");
  property p_fwd; fatal_det |=> fatal_msg == $past(serr_en_o); endproperty
  a_fwd: assert property (p_fwd)
    else $error("bad forward");
  property p_wr; cmd && pwrite && pstrb[0] |-> per_en_o == pwdata[6];
  endproperty
  a_wr: assert property (p_wr)
    else $error("enable not stored");
endmodule
bind pcec_top pcec_monitor pcec_monitor_inst (.*);

// >>> test/pcec_rc_model.sv
`timescale 1ns/100ps
module pcec_rc_model (
  input wire logic clk, rst, go, wr, pready, pslverr,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata, prdata,
  output logic psel, penable, pwrite, done, err,
  output logic [11:0] paddr,
  output logic [31:0] pwdata, rdata
);
  always @(posedge clk) begin
    done <= 1'h0;
    if (rst) begin
      {psel, penable, pwrite, err, paddr, pwdata} <= 48'h0;
    end else if (psel && penable && pready) begin
      {psel, penable, done, err} <= {3'h1, pslverr};
      rdata <= prdata;
      // flip released data so a stale word is never taken
      pwdata <= ~pwdata;
    end else if (psel) begin
      penable <= 1'h1;
    end else if (go && !done) begin
      {psel, pwrite, paddr, pwdata} <= {1'h1, wr, addr, wdata};
    end
  end
endmodule

// >>> test/pcie_command_error_control_bits_bench.sv
`timescale 1ns/100ps
module pcie_command_error_control_bits_bench;
  localparam logic [11:0] CMD = pcec_pkg::CMD_OFS;
  logic clk = 1'h0, rst = 1'h1, go = 1'h0, wr = 1'h0, done, err;
  logic parity_err_det = 1'h0, nonfatal_det = 1'h0, fatal_det = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, parity_resp;
  logic nonfatal_msg, fatal_msg, per_en_o, serr_en_o;
  logic [11:0] paddr, addr = 12'h0;
  logic [31:0] pwdata, prdata, rdata, wdata = 32'h0;
  int failures = 0, num_checks = 0, n;
  always #4 clk = ~clk;
  pcec_top pcec_top_inst (.*, .pstrb(4'hf));
  pcec_rc_model pcec_rc_model_inst (.*);
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h", $time, got);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    {wr, addr, wdata, go} <= {w, a, d, 1'h1};
    for (n = 0; n < 40 && done !== 1'h1; n++) @(negedge clk);
    if (n == 40) begin
      failures++;
      give_verdict();
    end
    @(posedge clk);
    go <= 1'h0;
  endtask
  task automatic pulse(input logic [2:0] e);
    @(posedge clk);
    {parity_err_det, nonfatal_det, fatal_det} <= e;
    @(posedge clk);
    {parity_err_det, nonfatal_det, fatal_det} <= 3'h0;
    @(negedge clk);
  endtask
  task automatic t_cmd;
    acc(1'h1, CMD, 32'hffffffff);
    acc(1'h0, CMD, 32'h0);
    chk(rdata, 32'h140);
    acc(1'h1, CMD, 32'h0);
    acc(1'h0, 12'hffc, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_par;
    pulse(3'h4);
    chk({31'h0, parity_resp}, 32'h0);
    acc(1'h0, pcec_pkg::ERRSTAT_OFS, 32'h0);
    chk(rdata & 32'h1, 32'h1);
    acc(1'h1, CMD, 32'h40);
    pulse(3'h4);
    chk({31'h0, parity_resp}, 32'h1);
  endtask
  task automatic t_serr;
    pulse(3'h3);
    chk({30'h0, nonfatal_msg, fatal_msg}, 32'h0);
    acc(1'h1, CMD, 32'h100);
    pulse(3'h3);
    chk({30'h0, nonfatal_msg, fatal_msg}, 32'h3);
  endtask
  task automatic t_stat;
    acc(1'h0, pcec_pkg::ERRCNT_OFS, 32'h0);
    chk(rdata, 32'h2);
    acc(1'h0, pcec_pkg::ERRSTAT_OFS, 32'h0);
    chk(rdata, 32'h7);
    acc(1'h1, pcec_pkg::ERRSTAT_OFS, 32'h7);
    acc(1'h1, pcec_pkg::ERRCNT_OFS, 32'h0);
    acc(1'h0, pcec_pkg::ERRSTAT_OFS, 32'h0);
    chk(rdata, 32'h0);
    acc(1'h0, pcec_pkg::ERRCNT_OFS, 32'h0);
    chk(rdata, 32'h0);
    chk({30'h0, per_en_o, serr_en_o}, 32'h1);
    // a reset in mid-run must bring both enables back to zero
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    acc(1'h0, CMD, 32'h0);
    chk(rdata, 32'h0);
    chk({30'h0, per_en_o, serr_en_o}, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    t_cmd();
    t_par();
    t_serr();
    t_stat();
    give_verdict();
  end
endmodule
